// File: rtl/igc_pkg.sv
// package of constants and types for the if gain control loop
// assumes one modulator clock domain at 200 MHz; no bus beyond the spi register port
package igc_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] REG_GAIN_HI = 8'h03;
	localparam logic [7:0] REG_GAIN_LO = 8'h04;
	localparam logic [7:0] REG_LOOP_TIME = 8'h05;
	localparam logic [7:0] REG_LOOP_CFG = 8'h06;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// field positions in the loop configuration byte
	localparam int DGE_BIT = 7;
	localparam int RRC_MSB = 6;
	localparam int RRC_LSB = 4;
	localparam int FAST_BIT = 3;
	localparam int REF_MSB = 2;
	localparam int REF_LSB = 0;
	// ==========================================
	// loop timing
	localparam int LOOP_PERIOD = 60;
	localparam logic [5:0] LOOP_LAST = 6'h3B;
	localparam logic [5:0] RSSI_FULL = 6'h3C;
	localparam int MANUAL_MIN_GAP = 240;
	// ==========================================
	// gain word layout
	localparam int GAIN_W = 16;
	localparam int ATT_MSB = 14;
	localparam logic [14:0] ATT_MAX = 15'h7FFF;
	localparam logic [14:0] ATT_ANALOG_MAX = 15'h3FFF;
	localparam logic [14:0] DGAIN_SPAN = 15'h4000;
	localparam logic [2:0] REF_MAX_CODE = 3'h5;
	// estimate and sample widths
	localparam int SAMP_W = 24;
	localparam int EST_W = 26;
	localparam int OUT_W = 16;
	// full-scale estimate at the clip level, 2x 23-bit magnitude
	localparam logic [25:0] EST_CLIP = 26'h0FFFFFE;
	typedef enum logic [1:0] {
		IGC_MANUAL = 2'b00,
		IGC_AUTO_ANALOG = 2'b01,
		IGC_AUTO_DIGITAL = 2'b10
	} igc_mode_t;
endpackage

// File: rtl/igc_est_if.sv
// interface carrying level estimates from the estimator to the loop
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface igc_est_if;
	logic [igc_pkg::EST_W-1:0] est_first;
	logic [igc_pkg::EST_W-1:0] est_out;
	logic est_valid;
	modport src (output est_first, output est_out, output est_valid);
	modport dst (input est_first, input est_out, input est_valid);
endinterface

// File: rtl/igc_estimator.sv
// level estimator: |i| + |q| at first decimation output and digital gain output
// assumes sample strobes are synchronous to clk_sys
`timescale 1ns/1ps
module igc_estimator (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic first_valid,
	input wire logic [igc_pkg::SAMP_W-1:0] first_i,
	input wire logic [igc_pkg::SAMP_W-1:0] first_q,
	input wire logic out_valid,
	input wire logic [igc_pkg::SAMP_W-1:0] out_i,
	input wire logic [igc_pkg::SAMP_W-1:0] out_q,
	input wire logic loop_tick,
	igc_est_if.src est
);
	typedef struct packed {
		logic [igc_pkg::EST_W-1:0] pk_first;
		logic [igc_pkg::EST_W-1:0] pk_out;
		logic [igc_pkg::EST_W-1:0] first;
		logic [igc_pkg::EST_W-1:0] outv;
		logic valid;
	} igc_est_state_t;
	igc_est_state_t s_q, s_d;

	// ==========================================
	// magnitude helper
	function automatic logic [igc_pkg::EST_W-1:0] mag_sum(
		input logic [igc_pkg::SAMP_W-1:0] i,
		input logic [igc_pkg::SAMP_W-1:0] q);
		logic [igc_pkg::SAMP_W-1:0] ai;
		logic [igc_pkg::SAMP_W-1:0] aq;
		ai = i[igc_pkg::SAMP_W-1] ? -i : i;
		aq = q[igc_pkg::SAMP_W-1] ? -q : q;
		mag_sum = {2'b00, ai} + {2'b00, aq};
	endfunction

	// peak hold over one loop period, handed over on the tick
	always_comb begin
		s_d = s_q;
		s_d.valid = 1'b0;
		if (first_valid && mag_sum(first_i, first_q) > s_q.pk_first) begin
			s_d.pk_first = mag_sum(first_i, first_q);
		end
		if (out_valid && mag_sum(out_i, out_q) > s_q.pk_out) begin
			s_d.pk_out = mag_sum(out_i, out_q);
		end
		if (loop_tick) begin
			s_d.first = s_d.pk_first;
			s_d.outv = s_d.pk_out;
			s_d.pk_first = '0;
			s_d.pk_out = '0;
			s_d.valid = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign est.est_first = s_q.first;
	assign est.est_out = s_q.outv;
	assign est.est_valid = s_q.valid;
endmodule

// File: rtl/igc_gain_loop.sv
// top of the if gain control loop: spi-written registers, loop, gain outputs
// assumes spi write strobes and sample strobes are on clk_sys; reset events too
`timescale 1ns/1ps

// Contract
// - reference code zero selects manual gain following the written gain word
// - gain word msb switches the fixed 16 dB mixer attenuator
// - lower 15 bits set attenuation; 14 effective without digital gain
// - analog gain drives an 8-bit control dac on the gain pin
// - 6-bit linear strength, updated every 60 clocks, 60 is full scale
// - automatic loop recomputes gain and state every 60 clocks
// - codes 1 to 5 pick targets 3 to 15 dB below clip
// - digital gain kept largest while output estimate stays under reference
// - level estimate is |i|+|q| at first decimation and digital gain output
// - frame carries overload and reset counts plus top 8 gain bits
// - attenuation report equals top eight bits of the gain word
// - above reference, attenuation rises by error scaled by attack code
// - below reference, attenuation falls by error scaled by attack minus decay
// - without digital gain, only analog gain from first-stage estimate
// - attack code sets bandwidth, sqrt two per step, scales with clock; the loop doubles its step per attack code step
// - decay code stretches decay by two to the half code; the loop halves its decay step per decay code step
// - each converter reset adds attenuation weighted by doubling code
// - fast acquire lowers dac source resistance by ten or more
// - digital gain from larger estimate, range 1 to 4
// - gain 4 drops two top bits; gain 1 takes top sixteen
// - at digital gain 1, further rise raises analog attenuation
// - digital gain stage active only when its enable bit is one
module igc_gain_loop (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic first_valid,
	input wire logic [igc_pkg::SAMP_W-1:0] first_i,
	input wire logic [igc_pkg::SAMP_W-1:0] first_q,
	input wire logic last_valid,
	input wire logic [igc_pkg::SAMP_W-1:0] last_i,
	input wire logic [igc_pkg::SAMP_W-1:0] last_q,
	input wire logic overload_evt,
	input wire logic conv_reset_evt,
	input wire logic frame_strobe,
	output logic [igc_pkg::OUT_W-1:0] out_i,
	output logic [igc_pkg::OUT_W-1:0] out_q,
	output logic out_valid,
	output logic [7:0] gain_dac_code,
	output logic mixer_atten_en,
	output logic fast_acquire_bit,
	output logic [5:0] rssi_field,
	output logic [7:0] atten_report_field,
	output logic [7:0] overload_count,
	output logic [7:0] conv_reset_count
);
	typedef struct packed {
		logic [15:0] gain_word;
		logic [3:0] attack_code;
		logic [3:0] decay_code;
		logic digital_gain_enable;
		logic [2:0] reset_response_code;
		logic fast;
		logic [2:0] ref_level_code;
		logic [5:0] div;
		logic tick;
		logic [1:0] dgain_sh;
		logic [7:0] rdata;
		logic [15:0] oi;
		logic [15:0] oq;
		logic ov;
		logic [7:0] dac;
		logic mix;
		logic [5:0] rssi;
		logic [7:0] att_rep;
		logic [7:0] ovl_cnt;
		logic [7:0] rst_cnt;
		logic [7:0] ovl_acc;
		logic [7:0] rst_acc;
		logic [7:0] rst_pend;
	} igc_top_state_t;
	igc_top_state_t s_q, s_d;

	logic [igc_pkg::SAMP_W-1:0] dg_i;
	logic [igc_pkg::SAMP_W-1:0] dg_q;
	igc_est_if est_bus ();

	// ==========================================
	// helpers
	// target level for a reference code, clip estimate scaled by 3 dB steps
	function automatic logic [igc_pkg::EST_W-1:0] ref_target(input logic [2:0] code);
		logic [igc_pkg::EST_W-1:0] c;
		c = igc_pkg::EST_CLIP;
		unique case (code)
			3'h1: ref_target = c - (c >> 2) - (c >> 5); // about -3 dB
			3'h2: ref_target = c >> 1;
			3'h3: ref_target = (c >> 2) + (c >> 3) - (c >> 6);
			3'h4: ref_target = c >> 2;
			3'h5: ref_target = (c >> 3) + (c >> 4) - (c >> 7);
			default: ref_target = c >> 3; // reserved codes, no promised level
		endcase
	endfunction

	// proportional step: error shifted by a gain code, bigger code bigger step
	function automatic logic [14:0] prop_step(
		input logic [igc_pkg::EST_W-1:0] err,
		input logic [4:0] k);
		logic [igc_pkg::EST_W-1:0] sh;
		sh = err >> (5'h18 - {1'b0, k[3:0]});
		prop_step = (sh > {11'h000, igc_pkg::ATT_MAX}) ? igc_pkg::ATT_MAX : sh[14:0];
	endfunction

	// saturating attenuation add, clamped to a limit
	function automatic logic [14:0] sat_add(input logic [14:0] a, input logic [14:0] b,
		input logic [14:0] lim);
		logic [15:0] t;
		t = {1'b0, a} + {1'b0, b};
		sat_add = (t > {1'b0, lim}) ? lim : t[14:0];
	endfunction

	// operating mode from the reference code and the digital gain enable
	function automatic igc_pkg::igc_mode_t loop_mode(input logic [2:0] code, input logic dge);
		if (code == 3'h0) begin
			loop_mode = igc_pkg::IGC_MANUAL;
		end else if (dge) begin
			loop_mode = igc_pkg::IGC_AUTO_DIGITAL;
		end else begin
			loop_mode = igc_pkg::IGC_AUTO_ANALOG;
		end
	endfunction

	// level steered on: larger estimate only while the digital stage is in use
	function automatic logic [igc_pkg::EST_W-1:0] pick_level(input logic dge,
		input logic [igc_pkg::EST_W-1:0] first, input logic [igc_pkg::EST_W-1:0] outv);
		if (dge && outv > first) begin
			pick_level = outv;
		end else begin
			pick_level = first;
		end
	endfunction

	// linear strength, 60 at the clip estimate; the 1/16 trim avoids a divider
	function automatic logic [5:0] rssi_code(input logic [igc_pkg::EST_W-1:0] lvl);
		logic [5:0] top;
		top = lvl[igc_pkg::SAMP_W-1 -: 6];
		if (lvl > igc_pkg::EST_CLIP) begin
			rssi_code = igc_pkg::RSSI_FULL;
		end else begin
			rssi_code = top - {4'h0, top[5:4]};
		end
	endfunction

	igc_estimator u_est (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.first_valid(first_valid),
		.first_i(first_i),
		.first_q(first_q),
		.out_valid(last_valid),
		.out_i(dg_i),
		.out_q(dg_q),
		.loop_tick(s_q.tick),
		.est(est_bus.src)
	);

	// digital gain applied before the output estimate; shift 2 is gain 4
	assign dg_i = last_i << s_q.dgain_sh;
	assign dg_q = last_q << s_q.dgain_sh;

	// ==========================================
	// next state
	always_comb begin
		logic [igc_pkg::EST_W-1:0] lvl;
		logic [igc_pkg::EST_W-1:0] tgt;
		logic [14:0] att;
		logic [14:0] lim;
		logic [4:0] kd;
		logic [7:0] rw;
		igc_pkg::igc_mode_t mode;
		mode = igc_pkg::IGC_MANUAL;
		lvl = '0;
		tgt = '0;
		att = '0;
		lim = '0;
		kd = '0;
		rw = '0;
		s_d = s_q;
		// spi writes; the host paces gain writes in manual mode
		if (reg_wr) begin
			unique case (reg_addr)
				igc_pkg::REG_GAIN_HI: s_d.gain_word[15:8] = reg_wdata;
				igc_pkg::REG_GAIN_LO: s_d.gain_word[7:0] = reg_wdata;
				igc_pkg::REG_LOOP_TIME: begin
					s_d.attack_code = reg_wdata[7:4];
					s_d.decay_code = reg_wdata[3:0];
				end
				igc_pkg::REG_LOOP_CFG: begin
					s_d.digital_gain_enable = reg_wdata[igc_pkg::DGE_BIT];
					s_d.reset_response_code = reg_wdata[igc_pkg::RRC_MSB:igc_pkg::RRC_LSB];
					s_d.fast = reg_wdata[igc_pkg::FAST_BIT];
					s_d.ref_level_code = reg_wdata[igc_pkg::REF_MSB:igc_pkg::REF_LSB];
				end
				default: ;
			endcase
		end
		// readback mux, unmapped addresses read zero
		unique case (reg_addr)
			igc_pkg::REG_GAIN_HI: s_d.rdata = s_q.gain_word[15:8];
			igc_pkg::REG_GAIN_LO: s_d.rdata = s_q.gain_word[7:0];
			igc_pkg::REG_LOOP_TIME: s_d.rdata = {s_q.attack_code, s_q.decay_code};
			igc_pkg::REG_LOOP_CFG: s_d.rdata = {s_q.digital_gain_enable,
				s_q.reset_response_code, s_q.fast, s_q.ref_level_code};
			default: s_d.rdata = igc_pkg::RESET_BYTE;
		endcase
		// loop divider: one tick per 60 clocks
		s_d.tick = (s_q.div == igc_pkg::LOOP_LAST);
		s_d.div = s_d.tick ? 6'h00 : s_q.div + 6'h01;
		// converter resets accumulate weight, doubling per code step
		if (conv_reset_evt) begin
			rw = 8'h01 << s_q.reset_response_code;
			s_d.rst_pend = (s_q.rst_pend > (8'hFF - rw)) ? 8'hFF : s_q.rst_pend + rw;
		end
		// automatic loop update on the estimate strobe one clock after the tick; manual mode leaves the written word alone
		mode = loop_mode(s_q.ref_level_code, s_q.digital_gain_enable);
		if (est_bus.est_valid && mode != igc_pkg::IGC_MANUAL) begin
			tgt = ref_target(s_q.ref_level_code);
			att = s_q.gain_word[14:0];
			lim = (mode == igc_pkg::IGC_AUTO_DIGITAL) ? igc_pkg::ATT_MAX :
				igc_pkg::ATT_ANALOG_MAX;
			// larger of both estimates with digital gain, first stage only without
			lvl = pick_level(s_q.digital_gain_enable, est_bus.est_first,
				est_bus.est_out);
			kd = {1'b0, s_q.attack_code} - {1'b0, s_q.decay_code};
			if (lvl > tgt) begin
				att = sat_add(att, prop_step(lvl - tgt, {1'b0, s_q.attack_code}), lim);
			end else if (!kd[4]) begin
				att = att - ((prop_step(tgt - lvl, kd) > att) ? att : prop_step(tgt - lvl, kd));
			end
			att = sat_add(att, {7'h00, s_q.rst_pend}, lim);
			s_d.rst_pend = conv_reset_evt ? rw : 8'h00;
			s_d.gain_word[14:0] = att;
		end
		// gain word split: msb to mixer, digital range below analog range
		s_d.mix = s_d.gain_word[15];
		if (s_d.digital_gain_enable) begin
			// low half of range is digital gain 4..1, upper half analog
			if (s_d.gain_word[14:0] < igc_pkg::DGAIN_SPAN) begin
				s_d.dgain_sh = 2'h2 - s_d.gain_word[13:12];
				s_d.dac = 8'h00;
			end else begin
				s_d.dgain_sh = 2'h0;
				s_d.dac = s_d.gain_word[13:6];
			end
		end else begin
			s_d.dgain_sh = 2'h0;
			s_d.dac = s_d.gain_word[13:6];
		end
		if (s_d.dgain_sh == 2'h3) begin
			s_d.dgain_sh = 2'h0;
		end
		// rssi: estimate scaled so 60 is full scale at current attenuation
		// same level as the loop, so strength stays flat while the loop tracks
		if (est_bus.est_valid) begin
			lvl = pick_level(s_q.digital_gain_enable, est_bus.est_first,
				est_bus.est_out);
			s_d.rssi = rssi_code(lvl);
		end
		// output word: gain 4 drops two msbs, gain 1 takes top sixteen
		s_d.ov = last_valid;
		if (last_valid) begin
			s_d.oi = dg_i[23:8];
			s_d.oq = dg_q[23:8];
		end
		// event counts per frame, latched with the frame strobe
		s_d.ovl_acc = s_q.ovl_acc + {7'h00, overload_evt & (s_q.ovl_acc != 8'hFF)};
		s_d.rst_acc = s_q.rst_acc + {7'h00, conv_reset_evt & (s_q.rst_acc != 8'hFF)};
		if (frame_strobe) begin
			s_d.ovl_cnt = s_d.ovl_acc;
			s_d.rst_cnt = s_d.rst_acc;
			s_d.ovl_acc = 8'h00;
			s_d.rst_acc = 8'h00;
		end
		s_d.att_rep = s_d.gain_word[15:8];
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// manual mode simply leaves the written word untouched
	assign reg_rdata = s_q.rdata;
	assign out_i = s_q.oi;
	assign out_q = s_q.oq;
	assign out_valid = s_q.ov;
	assign gain_dac_code = s_q.dac;
	assign mixer_atten_en = s_q.mix;
	assign fast_acquire_bit = s_q.fast;
	assign rssi_field = s_q.rssi;
	assign atten_report_field = s_q.att_rep;
	assign overload_count = s_q.ovl_cnt;
	assign conv_reset_count = s_q.rst_cnt;
endmodule

// File: tb/igc_gain_loop_properties.sv
// checker for the if gain control loop, bound to its top module
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module igc_gain_loop_properties (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic last_valid,
	input wire logic [igc_pkg::SAMP_W-1:0] last_i,
	input wire logic overload_evt,
	input wire logic frame_strobe,
	input wire logic [igc_pkg::OUT_W-1:0] out_i,
	input wire logic out_valid,
	input wire logic mixer_atten_en,
	input wire logic fast_acquire_bit,
	input wire logic [5:0] rssi_field,
	input wire logic [7:0] atten_report_field,
	input wire logic [7:0] overload_count
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ==========================================
	// shadow config and counters; gap starts saturated so the first update is free
	logic [2:0] ref_q;
	logic dge_q;
	logic [6:0] gap_q;
	logic [7:0] ov_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ref_q <= 3'h0;
			dge_q <= 1'b0;
			gap_q <= 7'h7F;
			ov_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == igc_pkg::REG_LOOP_CFG) begin
				ref_q <= reg_wdata[2:0];
				dge_q <= reg_wdata[7];
			end
			gap_q <= $changed(rssi_field) ? 7'h00 : ((gap_q == 7'h7F) ? gap_q : gap_q + 7'h01);
			ov_q <= frame_strobe ? 8'h00 : ((overload_evt && ov_q != 8'hFF) ? ov_q + 8'h01 : ov_q);
		end
	end
	// ==========================================
	// properties
	sequence s_gain_hi;
		reg_wr && reg_addr == igc_pkg::REG_GAIN_HI;
	endsequence
	AST_MIX_FOLLOW: assert property (s_gain_hi |=> mixer_atten_en == $past(reg_wdata[7]))
		else $error("mixer attenuator does not follow gain msb");
	AST_MIX_HOLD: assert property (ref_q == 3'h0 && !(reg_wr && reg_addr == 8'h03)
		|=> $stable(mixer_atten_en)) else $error("mixer attenuator moved unprompted");
	AST_ATT_TOP: assert property ((ref_q == 3'h0) ##0 s_gain_hi |=>
		atten_report_field == $past(reg_wdata)) else $error("attenuation report wrong");
	AST_MIX_REPORT: assert property (mixer_atten_en == atten_report_field[7])
		else $error("report msb and mixer bit disagree");
	AST_FAST: assert property (reg_wr && reg_addr == igc_pkg::REG_LOOP_CFG |=>
		fast_acquire_bit == $past(reg_wdata[3])) else $error("fast acquire bit wrong");
	AST_RSSI_MAX: assert property (rssi_field <= igc_pkg::RSSI_FULL)
		else $error("strength above full scale");
	AST_RSSI_PERIOD: assert property ($changed(rssi_field) |-> gap_q >= 7'd59)
		else $error("strength updated too soon");
	AST_OUT_VALID: assert property (out_valid == $past(last_valid))
		else $error("output strobe misplaced");
	AST_OUT_UNITY: assert property (last_valid && !dge_q |=>
		out_i == $past(last_i[23:8])) else $error("unity output not top bits");
	AST_OVL_COUNT: assert property (frame_strobe && !overload_evt |=>
		overload_count == $past(ov_q)) else $error("overload count wrong");
endmodule
bind igc_gain_loop igc_gain_loop_properties u_props (.*);

// File: tb/igc_host_model.sv
// host side model: byte register writes and reads
// assumes reg_rdata is registered one clock after the address
`timescale 1ns/1ps
module igc_host_model (
	input wire logic clk_sys,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	int cyc = 0;
	int mark = -1000;
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// ==========================================
	// cycle count for write spacing
	always @(posedge clk_sys) cyc <= cyc + 1;
	// one byte write; data lines inverted once released
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// gain word: high byte first, never faster than the rewrite gap
	task automatic set_gain(input logic [15:0] w);
		while (cyc - mark < igc_pkg::MANUAL_MIN_GAP) @(negedge clk_sys);
		mark = cyc;
		put(igc_pkg::REG_GAIN_HI, w[15:8]);
		put(igc_pkg::REG_GAIN_LO, w[7:0]);
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
endmodule

// File: tb/tb_top.sv
// testbench top for the if gain control loop
// assumes a 200 MHz clock; inputs move on the falling edge
`timescale 1ns/1ps
module tb_top;
	localparam int LIMIT = 40000;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic first_valid = 1'b0;
	logic [23:0] first_i = 24'h000000;
	logic [23:0] first_q = 24'h000000;
	logic last_valid = 1'b0;
	logic [23:0] last_i = 24'h000000;
	logic [23:0] last_q = 24'h000000;
	logic overload_evt = 1'b0;
	logic conv_reset_evt = 1'b0;
	logic frame_strobe = 1'b0;
	logic [15:0] out_i;
	logic [15:0] out_q;
	logic out_valid;
	logic [7:0] gain_dac_code;
	logic mixer_atten_en;
	logic fast_acquire_bit;
	logic [5:0] rssi_field;
	logic [7:0] atten_report_field;
	logic [7:0] overload_count;
	logic [7:0] conv_reset_count;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	igc_gain_loop u_dut (.*);
	igc_host_model u_host (.*);
	// ==========================================
	// clock and hang guard
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			close_out();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic drive(input logic en, input logic [23:0] v);
		first_valid = en;
		last_valid = en;
		first_i = v;
		first_q = v;
		last_i = v;
		last_q = v;
	endtask
	// n cycles of samples on both taps, then released
	task automatic feed(input int n, input logic [23:0] v);
		repeat (n) begin
			@(negedge clk_sys);
			drive(1'b1, v);
		end
		@(negedge clk_sys);
		drive(1'b0, ~v);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [7:0] d;
		check("mixer", mixer_atten_en, 0);
		for (int a = 3; a <= 7; a++) begin
			u_host.get(a[7:0], d);
			check("reg reset", d, 0);
		end
		$display("test reset done");
	endtask
	task automatic t_manual();
		logic [7:0] d;
		logic [23:0] v;
		v = 24'h0ABCDE;
		u_host.set_gain(16'hA5C3);
		check("mixer", mixer_atten_en, 1);
		check("atten", atten_report_field, 8'hA5);
		check("dac", gain_dac_code, 8'h97);
		u_host.get(igc_pkg::REG_GAIN_LO, d);
		check("gain lo", d, 8'hC3);
		u_host.set_gain(16'h4040);
		check("dac bit14", gain_dac_code, 8'h01);
		check("mixer off", mixer_atten_en, 0);
		u_host.set_gain(16'h0000);
		feed(1, v);
		check("valid", out_valid, 1);
		check("unity", out_i, v[23:8]);
		check("unity q", out_q, v[23:8]);
		$display("test manual done");
	endtask
	task automatic t_digital();
		logic [23:0] v;
		v = 24'h0ABCDE;
		u_host.put(igc_pkg::REG_LOOP_CFG, 8'h88);
		check("fast", fast_acquire_bit, 1);
		feed(1, v);
		check("gain4", out_i, v[21:6]);
		u_host.set_gain(16'h3000);
		feed(1, v);
		check("gain1", out_i, v[23:8]);
		$display("test digital done");
	endtask
	task automatic t_auto();
		logic [7:0] a;
		u_host.put(igc_pkg::REG_LOOP_TIME, 8'hF0);
		for (int c = 1; c <= 5; c++) begin
			u_host.put(igc_pkg::REG_LOOP_CFG, 8'h00);
			u_host.set_gain(16'h0000);
			u_host.put(igc_pkg::REG_LOOP_CFG, c[7:0]);
			feed(600, 24'h7FFFFF);
			a = atten_report_field;
			check("attack", a > 8'h00, 1);
			check("rssi", rssi_field, igc_pkg::RSSI_FULL);
			feed(600, 24'h000100);
			check("decay", atten_report_field < a, 1);
		end
		$display("test auto done");
	endtask
	// digital stage in the loop: full scale pushes into analog range, quiet returns to gain 4
	task automatic t_auto_dg();
		logic [23:0] v;
		v = 24'h0ABCDE;
		u_host.put(igc_pkg::REG_LOOP_TIME, 8'hF2);
		u_host.put(igc_pkg::REG_LOOP_CFG, 8'h00);
		u_host.set_gain(16'h0000);
		u_host.put(igc_pkg::REG_LOOP_CFG, 8'h83);
		feed(600, 24'h7FFFFF);
		check("dg atten", atten_report_field, 8'h7F);
		check("dg dac", gain_dac_code, 8'hFF);
		feed(1080, 24'h000100);
		check("dg recover", atten_report_field, 8'h00);
		check("dg dac off", gain_dac_code, 8'h00);
		feed(1, v);
		check("dg gain4", out_i, v[21:6]);
		u_host.put(igc_pkg::REG_LOOP_CFG, 8'h00);
		$display("test auto digital done");
	endtask
	task automatic pulse(input int ov, input int rs);
		repeat (ov) begin
			@(negedge clk_sys);
			overload_evt = 1'b1;
			@(negedge clk_sys);
			overload_evt = 1'b0;
		end
		repeat (rs) begin
			@(negedge clk_sys);
			conv_reset_evt = 1'b1;
			@(negedge clk_sys);
			conv_reset_evt = 1'b0;
		end
		@(negedge clk_sys);
		frame_strobe = 1'b1;
		@(negedge clk_sys);
		frame_strobe = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic t_events();
		u_host.put(igc_pkg::REG_LOOP_CFG, 8'h00);
		pulse(3, 2);
		check("ovl", overload_count, 3);
		check("rst", conv_reset_count, 2);
		pulse(0, 0);
		check("ovl empty", overload_count, 0);
		$display("test events done");
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		resetn = 1'b1;
		t_reset();
		t_manual();
		t_digital();
		t_auto();
		t_auto_dg();
		t_events();
		close_out();
	end
endmodule
